// ---- core/nci_regs.svh ----
// nci_regs.svh - offsets, fields, reset values and codes of the command block
// assumes: included by bare name from the package only; the core module uses its macros without including it
`ifndef NCI_REGS_SVH
`define NCI_REGS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define NCI_CTRL_OFS      6'h00
`define NCI_CTRL_RST      16'h0000
`define NCI_CODE_MSB      6
`define NCI_CODE_LSB      0
`define NCI_KEY_MSB       15
`define NCI_KEY_LSB       8
`define NCI_EXEC_KEY      8'hA5

// ----------------------------------------
// command codes
// ----------------------------------------
`define NCI_C_ROW_WIPE    7'h02
`define NCI_C_PAGE_PROG   7'h04
`define NCI_C_AUX_WIPE    7'h05
`define NCI_C_AUX_PROG    7'h06
`define NCI_C_LOCK_PROG   7'h0F
`define NCI_C_EE_WIPE     7'h1A
`define NCI_C_EE_PROG     7'h1C
`define NCI_C_RGN_LOCK    7'h40
`define NCI_C_RGN_UNLOCK  7'h41
`define NCI_C_PR_SET      7'h42
`define NCI_C_PR_CLR      7'h43
`define NCI_C_PB_CLR      7'h44
`define NCI_C_SEC_SET     7'h45
`define NCI_C_FLUSH       7'h46
`define NCI_C_DR_LOCK     7'h47
`define NCI_C_DR_UNLOCK   7'h48

// value programmed into the first lock-row byte to set security
`define NCI_SEC_BYTE      8'h00

`endif

// ---- core/nci_pkg.sv ----
// nci_pkg.sv - types shared by the command block and its bench
// assumes: nci_regs.svh on the include path
`default_nettype none

package nci_pkg;
    `include "nci_regs.svh"

    // operation handed to the flash array
    typedef enum logic [3:0] {
        NCI_OP_NONE      = 4'h0,
        NCI_OP_ROW_WIPE  = 4'h1,
        NCI_OP_PAGE_PROG = 4'h2,
        NCI_OP_AUX_WIPE  = 4'h3,
        NCI_OP_AUX_PROG  = 4'h4,
        NCI_OP_LOCK_PROG = 4'h5,
        NCI_OP_EE_WIPE   = 4'h6,
        NCI_OP_EE_PROG   = 4'h7,
        NCI_OP_RGN_LOCK  = 4'h8,
        NCI_OP_RGN_UNLK  = 4'h9,
        NCI_OP_PR_SET    = 4'hA,
        NCI_OP_PR_CLR    = 4'hB,
        NCI_OP_PB_CLR    = 4'hC,
        NCI_OP_SEC_SET   = 4'hD,
        NCI_OP_DR_LOCK   = 4'hE,
        NCI_OP_DR_UNLK   = 4'hF
    } nci_op_t;

    // one issued operation: kind, byte address, data byte
    typedef struct packed {
        nci_op_t     kind;
        logic [22:0] byte_addr;
        logic [7:0]  data;
    } nci_req_t;
endpackage : nci_pkg

`default_nettype wire

// ---- core/nci_core.sv ----
// nci_core.sv - command issue logic of the flash controller
// assumes: one clock, registers reached over a byte-lane write/read port,
// address, lock, security and busy state supplied by the neighbouring logic
`default_nettype none

// Summary of operation
// - 8, 16 and 32 bit accesses and each byte lane work independently
// - enable-protect mask bits 0 and 8 make their whole byte lane ignore writes while the module is enabled
// - command runs only when key 0xA5 and 7-bit code arrive together
// - wrong key performs nothing and sets the programming error flag
// - keyed command while previous one unfinished sets programming error
// - system bus access wins; command waits for memory and bus idle
// - key bit 0 reads one until the command reaches the memory
// - address field counts halfwords, not bytes
// - code 0x02 erases the addressed main-array row
// - code 0x04 programs page buffer into addressed main page
// - 0x05 and 0x06 only with security clear and on user row
// - code 0x0F writes lock register into non-volatile lock bits
// - 0x40 locks, 0x41 unlocks region holding the address
// - 0x42 sets, 0x43 clears power reduction mode
// - 0x44 clears the whole page buffer
// - 0x45 sets security by writing 0x00 to first lock byte
// - 0x46 invalidates every read-cache line
// - 0x47/0x48 lock/unlock data region; secure regions need secure access
// - every content-changing command also invalidates the read cache
// - manual write on: page writes only by keyed command
module nci_core #(
    parameter logic [15:0] ENPROT_MASK = 16'h0000,
    parameter logic [21:0] USER_ROW    = 22'h000000,
    parameter int          ROW_HW_BITS = 7
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    input  wire logic [5:0]       reg_addr,
    input  wire logic [3:0]       reg_be,
    input  wire logic [31:0]      reg_wdata,
    output logic      [31:0]      reg_rdata,
    input  wire logic             module_enabled,
    input  wire logic             sysbus_access,
    input  wire logic             sysbus_busy,
    input  wire logic             mem_busy,
    input  wire logic [21:0]      nvm_addr_hw,
    input  wire logic [7:0]       lock_reg_byte,
    input  wire logic             security_bit,
    input  wire logic             sec_ext_enabled,
    input  wire logic             region_is_secure,
    input  wire logic             access_secure,
    input  wire logic             manual_page_write,
    input  wire logic             pb_last_word_wr,
    input  wire logic             error_clear,
    output logic                  ready,
    output logic                  program_error_flag,
    output logic                  mem_req_valid,
    output nci_pkg::nci_req_t     mem_req,
    output logic                  cache_flush_all
);
    import nci_pkg::*;

    // ----------------------------------------
    // functions
    // ----------------------------------------
    // map a command code onto an array operation
    function automatic nci_op_t code_to_op(input logic [6:0] c);
        nci_op_t o;
        o = NCI_OP_NONE;
        case (c)
            `NCI_C_ROW_WIPE:   o = NCI_OP_ROW_WIPE;
            `NCI_C_PAGE_PROG:  o = NCI_OP_PAGE_PROG;
            `NCI_C_AUX_WIPE:   o = NCI_OP_AUX_WIPE;
            `NCI_C_AUX_PROG:   o = NCI_OP_AUX_PROG;
            `NCI_C_LOCK_PROG:  o = NCI_OP_LOCK_PROG;
            `NCI_C_EE_WIPE:    o = NCI_OP_EE_WIPE;
            `NCI_C_EE_PROG:    o = NCI_OP_EE_PROG;
            `NCI_C_RGN_LOCK:   o = NCI_OP_RGN_LOCK;
            `NCI_C_RGN_UNLOCK: o = NCI_OP_RGN_UNLK;
            `NCI_C_PR_SET:     o = NCI_OP_PR_SET;
            `NCI_C_PR_CLR:     o = NCI_OP_PR_CLR;
            `NCI_C_PB_CLR:     o = NCI_OP_PB_CLR;
            `NCI_C_SEC_SET:    o = NCI_OP_SEC_SET;
            `NCI_C_DR_LOCK:    o = NCI_OP_DR_LOCK;
            `NCI_C_DR_UNLOCK:  o = NCI_OP_DR_UNLK;
            default:           o = NCI_OP_NONE;
        endcase
        return o;
    endfunction

    // true for operations that change array contents
    function automatic logic alters_array(input nci_op_t o);
        logic r;
        r = 1'b0;
        case (o)
            NCI_OP_ROW_WIPE, NCI_OP_PAGE_PROG,
            NCI_OP_AUX_WIPE, NCI_OP_AUX_PROG,
            NCI_OP_LOCK_PROG, NCI_OP_EE_WIPE,
            NCI_OP_EE_PROG, NCI_OP_SEC_SET: r = 1'b1;
            default:                        r = 1'b0;
        endcase
        return r;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [0:0] {
        NCI_S_IDLE = 1'b0,
        NCI_S_WAIT = 1'b1
    } nci_state_t;

    nci_state_t  state_q;
    nci_state_t  state_d;
    logic [6:0]  code_q;
    logic        perr_q;
    logic        issue_q;
    nci_req_t    req_q;
    logic        flush_q;

    // ----------------------------------------
    // register write decode
    // ----------------------------------------
    wire logic       hit_ctrl;
    wire logic       lane_code;
    wire logic       lane_key;
    wire logic [7:0] key_in;
    wire logic [6:0] code_in;
    wire logic       key_ok;
    wire logic       key_try;
    wire logic       busy;
    wire logic       accept;
    wire logic       reject;

    // each lane of the word is written on its own strobe
    assign hit_ctrl  = reg_addr[5:2] == 4'(`NCI_CTRL_OFS >> 2);
    assign lane_code = reg_wr && hit_ctrl && reg_be[0]
                       && !(module_enabled && ENPROT_MASK[0]);
    assign lane_key  = reg_wr && hit_ctrl && reg_be[1]
                       && !(module_enabled && ENPROT_MASK[8]);
    assign key_in    = reg_wdata[`NCI_KEY_MSB:`NCI_KEY_LSB];
    assign code_in   = reg_wdata[`NCI_CODE_MSB:`NCI_CODE_LSB];

    // key must come with the code in one write
    assign key_ok    = lane_code && key_in == `NCI_EXEC_KEY;
    assign key_try   = lane_key;
    assign busy      = state_q == NCI_S_WAIT || mem_busy;
    assign accept    = key_try && key_ok && !busy;
    assign reject    = key_try && (!key_ok || busy);

    // ----------------------------------------
    // issue decision
    // ----------------------------------------
    wire logic    path_free;
    wire logic    go;
    wire nci_op_t op_raw;
    wire logic    user_row_hit;
    wire logic    aux_op;
    wire logic    aux_ok;
    wire logic    dr_op;
    wire logic    dr_ok;
    wire logic    allowed;
    wire logic    auto_prog;
    wire logic [22:0] addr_bytes;

    // system bus traffic holds the command back
    assign path_free  = !sysbus_access && !sysbus_busy && !mem_busy;
    assign go         = state_q == NCI_S_WAIT && path_free;
    assign op_raw     = code_to_op(code_q);

    // aux commands need security clear and the user row
    assign user_row_hit = (nvm_addr_hw >> ROW_HW_BITS)
                          == (USER_ROW >> ROW_HW_BITS);
    assign aux_op     = op_raw == NCI_OP_AUX_WIPE || op_raw == NCI_OP_AUX_PROG;
    assign aux_ok     = !security_bit && user_row_hit;

    // secure data regions need a secure access
    assign dr_op      = op_raw == NCI_OP_DR_LOCK || op_raw == NCI_OP_DR_UNLK;
    assign dr_ok      = !(sec_ext_enabled && region_is_secure && !access_secure);

    assign allowed    = (!aux_op || aux_ok) && (!dr_op || dr_ok);

    // halfword address becomes a byte address
    assign addr_bytes = {nvm_addr_hw, 1'b0};

    // last-word page write only when manual write is off
    assign auto_prog  = pb_last_word_wr && !manual_page_write
                        && state_q == NCI_S_IDLE && !mem_busy;

    // ----------------------------------------
    // state machine
    // ----------------------------------------
    // a keyed write parks the command until the path is free
    always_comb begin
        state_d = state_q;
        case (state_q)
            NCI_S_IDLE: begin
                if (accept) begin
                    state_d = NCI_S_WAIT;
                end
            end
            NCI_S_WAIT: begin
                if (go) begin
                    state_d = NCI_S_IDLE;
                end
            end
            default: state_d = NCI_S_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= NCI_S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------
    // command code field
    // ----------------------------------------
    // code lane stores whenever written; frozen while waiting
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            code_q <= 7'(`NCI_CTRL_RST);
        end else if (lane_code && state_q == NCI_S_IDLE) begin
            code_q <= code_in;
        end
    end

    // ----------------------------------------
    // programming error flag
    // ----------------------------------------
    wire logic perr_set;

    assign perr_set = reject || (go && !allowed);

    // set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            perr_q <= 1'b0;
        end else if (perr_set) begin
            perr_q <= 1'b1;
        end else if (error_clear) begin
            perr_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // request to the array
    // ----------------------------------------
    wire logic     do_cmd;
    wire nci_req_t req_d;
    wire nci_op_t  kind_d;

    assign do_cmd = go && allowed && op_raw != NCI_OP_NONE;
    assign kind_d = auto_prog ? NCI_OP_PAGE_PROG : op_raw;
    assign req_d.kind      = kind_d;
    assign req_d.byte_addr = addr_bytes;
    assign req_d.data      = (op_raw == NCI_OP_SEC_SET) ?
                             `NCI_SEC_BYTE : lock_reg_byte;

    // one-cycle request with its payload held in flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            issue_q <= 1'b0;
            req_q   <= '0;
        end else begin
            issue_q <= do_cmd || auto_prog;
            if (do_cmd || auto_prog) begin
                req_q <= req_d;
            end
        end
    end

    // ----------------------------------------
    // cache invalidate
    // ----------------------------------------
    wire logic flush_d;

    assign flush_d = (go && allowed && code_q == `NCI_C_FLUSH)
                     || (do_cmd && alters_array(op_raw))
                     || auto_prog;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flush_q <= 1'b0;
        end else begin
            flush_q <= flush_d;
        end
    end

    // ----------------------------------------
    // read path and outputs
    // ----------------------------------------
    wire logic [15:0] ctrl_view;

    // key bit 0 shows a command still waiting
    assign ctrl_view = {7'h00, state_q == NCI_S_WAIT, 1'b0, code_q};

    // upper half and unmapped words read as zero
    assign reg_rdata = (reg_rd && hit_ctrl) ? {16'h0000, ctrl_view} : 32'h0000_0000;

    // ready lets software know a new command may go in
    assign ready              = !busy;
    assign program_error_flag = perr_q;
    assign mem_req_valid      = issue_q;
    assign mem_req            = req_q;
    assign cache_flush_all    = flush_q;

endmodule // nci_core

`default_nettype wire

// ---- verification/nci_checker.sv ----
// nci_checker.sv - concurrent checks on the command issue block
// assumes: bound into nci_core, one clock, active-low async reset
`default_nettype none
module nci_checker (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [5:0]        reg_addr,
    input wire logic [3:0]        reg_be,
    input wire logic [31:0]       reg_wdata,
    input wire logic [31:0]       reg_rdata,
    input wire logic              sysbus_access,
    input wire logic              sysbus_busy,
    input wire logic              mem_busy,
    input wire logic [21:0]       nvm_addr_hw,
    input wire logic              manual_page_write,
    input wire logic              pb_last_word_wr,
    input wire logic              error_clear,
    input wire logic              ready,
    input wire logic              program_error_flag,
    input wire logic              mem_req_valid,
    input wire nci_pkg::nci_req_t mem_req,
    input wire logic              cache_flush_all
);
    timeunit 1ns;
    timeprecision 100ps;
    import nci_pkg::*;
    // ----------------------------------------
    // port activity decode
    // ----------------------------------------
    wire ctl_wr = reg_wr && (reg_addr[5:2] == 4'h0);
    wire ctl_rd = reg_rd && (reg_addr[5:2] == 4'h0);
    wire key_ok = ctl_wr && (reg_be[1:0] == 2'b11) && (reg_wdata[15:8] == 8'hA5);
    wire key_bad = ctl_wr && reg_be[1] && (reg_wdata[15:8] != 8'hA5);
    wire free = !sysbus_access && !sysbus_busy && !mem_busy;
    wire waiting = !ready && !mem_busy;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    // keyed page write from idle, then a free path cycle
    sequence s_page_cmd;
        key_ok && ready && (reg_wdata[6:0] == 7'h04);
    endsequence
    sequence s_free;
        free;
    endsequence
    a_page_issue: assert property (s_page_cmd ##1 s_free |=> mem_req_valid && mem_req.kind == NCI_OP_PAGE_PROG
        && mem_req.byte_addr == {$past(nvm_addr_hw), 1'b0}) else $error("page write not issued");
    a_wrong_key: assert property (key_bad |=> program_error_flag) else $error("bad key without error");
    a_wrong_noop: assert property (key_bad && ready && !pb_last_word_wr |=> !mem_req_valid)
        else $error("bad key issued a request");
    a_busy_error: assert property (key_ok && mem_busy |=> program_error_flag) else $error("busy write no error");
    a_blocked_hold: assert property (!free && !pb_last_word_wr |=> !mem_req_valid)
        else $error("issued on busy path");
    a_key_readback: assert property (ctl_rd && waiting |-> reg_rdata[8]) else $error("key bit low while waiting");
    a_key_clear: assert property (ctl_rd && ready |-> !reg_rdata[8]) else $error("key bit high when idle");
    a_flush_write: assert property (mem_req_valid && mem_req.kind inside {NCI_OP_ROW_WIPE, NCI_OP_PAGE_PROG,
        NCI_OP_AUX_WIPE, NCI_OP_AUX_PROG, NCI_OP_LOCK_PROG, NCI_OP_SEC_SET,
        NCI_OP_EE_WIPE, NCI_OP_EE_PROG} |-> cache_flush_all) else $error("no flush on write");
    a_manual_hold: assert property (manual_page_write && pb_last_word_wr && ready |=> !mem_req_valid)
        else $error("auto write under manual mode");
    a_error_sticky: assert property (program_error_flag && !error_clear |=> program_error_flag)
        else $error("error flag dropped");
    a_issue_cause: assert property (mem_req_valid |-> !$past(ready) || $past(pb_last_word_wr))
        else $error("request without command");
endmodule // nci_checker

bind nci_core nci_checker chk_u (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sysbus_access(sysbus_access), .sysbus_busy(sysbus_busy), .mem_busy(mem_busy),
    .nvm_addr_hw(nvm_addr_hw), .manual_page_write(manual_page_write), .pb_last_word_wr(pb_last_word_wr),
    .error_clear(error_clear), .ready(ready), .program_error_flag(program_error_flag),
    .mem_req_valid(mem_req_valid), .mem_req(mem_req), .cache_flush_all(cache_flush_all));
`default_nettype wire

// ---- verification/nci_flash_model.sv ----
// nci_flash_model.sv - flash array stand-in, busy for a set time per operation
// assumes: requests arrive as one-cycle pulses from nci_core
`default_nettype none
module nci_flash_model (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              mem_req_valid,
    input  wire nci_pkg::nci_req_t mem_req,
    input  wire logic [7:0]        busy_len,
    output logic                   mem_busy
);
    timeunit 1ns;
    timeprecision 100ps;
    import nci_pkg::*;
    logic [7:0] cnt_q;
    // ----------------------------------------
    // array operation timer
    // ----------------------------------------
    // every array operation holds busy for busy_len cycles, blocking issue
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) cnt_q <= 8'h00;
        else if (mem_req_valid && mem_req.kind != NCI_OP_NONE) cnt_q <= busy_len;
        else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
    end
    assign mem_busy = (cnt_q != 8'h00);
endmodule // nci_flash_model
`default_nettype wire

// ---- verification/testbench.sv ----
// testbench.sv - register-level tests of the command issue block
// assumes: default parameters, user row 0, flash model as array
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import nci_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, enabled = 1'b1, sys_acc = 1'b0;
    logic sys_busy = 1'b0, sec_bit = 1'b0, sec_ext = 1'b0, rgn_sec = 1'b0, acc_sec = 1'b0;
    logic manual = 1'b1, pb_last = 1'b0, err_clr = 1'b0, ready, perr, req_v, flush, mem_busy;
    logic [5:0]  reg_addr = 6'h00;
    logic [3:0]  reg_be = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [21:0] addr_hw = 22'h000010;
    logic [7:0]  lock_byte = 8'h5A, busy_len = 8'h03;
    nci_req_t    mem_req;
    int          error_cnt = 0, cmp_count = 0, cyc = 0, i;
    logic [6:0]  codes[16] = '{7'h02, 7'h04, 7'h05, 7'h06, 7'h0F, 7'h1A, 7'h1C, 7'h40, 7'h41, 7'h42, 7'h43,
                               7'h44, 7'h45, 7'h46, 7'h47, 7'h48};
    logic [3:0]  kinds[16] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD,
                               4'h0, 4'hE, 4'hF};
    // codes with no operation behind them
    logic [6:0]  rsv[8] = '{7'h00, 7'h01, 7'h03, 7'h07, 7'h0E, 7'h1B, 7'h1D, 7'h49};
    logic        seen;
    nci_core dut_u (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .module_enabled(enabled),
        .sysbus_access(sys_acc), .sysbus_busy(sys_busy), .mem_busy(mem_busy), .nvm_addr_hw(addr_hw),
        .lock_reg_byte(lock_byte), .security_bit(sec_bit), .sec_ext_enabled(sec_ext),
        .region_is_secure(rgn_sec), .access_secure(acc_sec), .manual_page_write(manual),
        .pb_last_word_wr(pb_last), .error_clear(err_clr), .ready(ready), .program_error_flag(perr),
        .mem_req_valid(req_v), .mem_req(mem_req), .cache_flush_all(flush));
    nci_flash_model flash_u (.clk(clk), .rst_n(rst_n), .mem_req_valid(req_v), .mem_req(mem_req),
        .busy_len(busy_len), .mem_busy(mem_busy));
    // ----------------------------------------
    // clock, watchdog and access tasks
    // ----------------------------------------
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            close_out();
        end
    end
    task automatic chk(input logic [36:0] got, input logic [36:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] d, input logic [3:0] be);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_be <= be;
        reg_addr <= 6'h00;
        reg_wdata <= {16'h0000, d};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(negedge clk);
        chk({5'h00, reg_rdata}, {5'h00, exp});
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    // waits for the request or flush of a command, then checks its fields
    task automatic wreq(input logic [3:0] k);
        int n;
        logic au, fl;
        n = 0;
        au = k inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hE, 4'hF};
        fl = k inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hD};
        #1;
        while (req_v !== 1'b1 && flush !== 1'b1 && n < 30) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({req_v, flush | !fl, (k == 4'h0) ? 4'h0 : mem_req.kind, au ? mem_req.byte_addr : 23'h0,
             (k == 4'h5 || k == 4'hD) ? mem_req.data : 8'h00},
            {k != 4'h0, 1'b1, k, au ? {addr_hw, 1'b0} : 23'h0, (k == 4'h5) ? lock_byte : 8'h00});
    endtask
    task automatic wrdy;
        int n;
        n = 0;
        repeat (2) @(posedge clk);
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (ready !== 1'b1 && n < 100);
        chk({36'h0, ready}, 37'h1);
        @(posedge clk);
    endtask
    task automatic err_is(input logic e, input string s);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk({36'h0, perr}, {36'h0, e});
        @(posedge clk);
        err_clr <= 1'b1;
        @(posedge clk);
        err_clr <= 1'b0;
        $display("test %0s done, mismatches %0d", s, error_cnt);
    endtask
    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd(6'h00, 32'h0000_0000);
        rd(6'h10, 32'h0000_0000);
        err_is(1'b0, "reset");
        for (i = 0; i < 16; i++) begin
            wr({8'hA5, 1'b0, codes[i]}, i[0] ? 4'h3 : 4'hF);
            wreq(kinds[i]);
            wrdy();
        end
        err_is(1'b0, "commands");
        wr(16'h5A02, 4'h3);
        err_is(1'b1, "wrong key");
        wr(16'hA500, 4'h2);
        err_is(1'b1, "split key");
        busy_len <= 8'h40;
        wr(16'hA502, 4'h3);
        wreq(4'h1);
        wr(16'hA504, 4'h3);
        err_is(1'b1, "busy");
        busy_len <= 8'h03;
        wrdy();
        sys_acc <= 1'b1;
        wr(16'hA504, 4'h3);
        repeat (4) @(posedge clk);
        rd(6'h00, 32'h0000_0104);
        @(negedge clk);
        chk({36'h0, req_v}, 37'h0);
        @(posedge clk);
        sys_acc <= 1'b0;
        wreq(4'h2);
        wrdy();
        sec_bit <= 1'b1;
        wr(16'hA505, 4'h3);
        err_is(1'b1, "secure aux");
        sec_bit <= 1'b0;
        addr_hw <= 22'h000100;
        wr(16'hA506, 4'h3);
        err_is(1'b1, "aux row");
        addr_hw <= 22'h000010;
        sec_ext <= 1'b1;
        rgn_sec <= 1'b1;
        wr(16'hA547, 4'h3);
        err_is(1'b1, "data region");
        acc_sec <= 1'b1;
        wr(16'hA548, 4'h3);
        wreq(4'hF);
        wrdy();
        // reserved codes: no request and no flush in the cycles after the write
        foreach (rsv[j]) begin
            wr({8'hA5, 1'b0, rsv[j]}, 4'h3);
            seen = 1'b0;
            repeat (4) begin
                @(negedge clk);
                seen = seen | req_v | flush;
            end
            chk({36'h0, seen}, 37'h0);
        end
        err_is(1'b0, "reserved");
        manual <= 1'b0;
        pb_last <= 1'b1;
        @(posedge clk);
        pb_last <= 1'b0;
        wreq(4'h2);
        wrdy();
        manual <= 1'b1;
        pb_last <= 1'b1;
        @(posedge clk);
        pb_last <= 1'b0;
        @(negedge clk);
        chk({36'h0, req_v}, 37'h0);
        err_is(1'b0, "auto write");
        close_out();
    end
endmodule // testbench
`default_nettype wire
